/* File: include/dsau_pkg.sv */
// shared constants of the data space address unit
package dsau_pkg;

   // ==========================================================
   // register byte offsets on the apb side
   localparam logic [7:0]  OFF_MODULO_CONTROL = 8'h00;
   localparam logic [7:0]  OFF_X_BUFFER_START = 8'h04;
   localparam logic [7:0]  OFF_X_BUFFER_END   = 8'h08;
   localparam logic [7:0]  OFF_Y_BUFFER_START = 8'h0C;
   localparam logic [7:0]  OFF_Y_BUFFER_END   = 8'h10;
   localparam logic [7:0]  OFF_BITREV_CONTROL = 8'h14;
   localparam logic [7:0]  OFF_ERROR_ADDRESS  = 8'h18;
   localparam logic [7:0]  OFF_ERROR_FLAGS    = 8'h1C;

   // ==========================================================
   // field positions
   localparam int          X_SEL_LSB          = 0;
   localparam int          Y_SEL_LSB          = 4;
   localparam int          X_ENABLE_BIT       = 15;
   localparam int          Y_ENABLE_BIT       = 14;
   localparam int          BREV_ENABLE_BIT    = 15;
   localparam int          BREV_SEL_LSB       = 8;
   localparam int          BREV_MOD_LSB       = 0;
   localparam int          ERR_SEEN_BIT       = 0;
   localparam logic [3:0]  SEL_DISABLED       = 4'hF;

   // ==========================================================
   // reset values
   localparam logic [15:0] MODULO_CONTROL_RST = 16'h00FF;
   localparam logic [15:0] BUFFER_ADDR_RST    = 16'h0000;
   localparam logic [15:0] BITREV_CONTROL_RST = 16'h0F00;

   // ==========================================================
   // fixed prefetch pointers of the dual read instructions
   localparam logic [3:0]  X_PREFETCH_POINTER_A = 4'h8;
   localparam logic [3:0]  X_PREFETCH_POINTER_B = 4'h9;
   localparam logic [3:0]  Y_PREFETCH_POINTER_A = 4'hA;
   localparam logic [3:0]  Y_PREFETCH_POINTER_B = 4'hB;

   // ==========================================================
   // memory map, fixed in hardware
   localparam logic [15:0] RAM_FIRST          = 16'h0800;
   localparam logic [15:0] RAM_LAST           = 16'h0BFF;
   localparam logic [15:0] Y_SPACE_FIRST      = 16'h0A00;
   localparam logic [15:0] Y_SPACE_LAST       = 16'h0BFF;
   localparam int          RAM_WORDS          = 512;
   localparam int          RAM_AW             = 9;
   localparam logic [15:0] STEP_BYTE          = 16'h0001;
   localparam logic [15:0] STEP_WORD          = 16'h0002;

endpackage

/* File: include/dsau_agu_if.sv */
// pointer update request and result between top and address generator
`timescale 1ns/1ps
interface dsau_agu_if;
   logic [15:0] ptr;
   logic        step_en;
   logic        step_dn;
   logic        byte_op;
   logic        mod_en;
   logic [15:0] mod_start;
   logic [15:0] mod_end;
   logic        brev_en;
   logic [7:0]  brev_mod;
   logic [15:0] next;

   modport ctrl (output ptr, step_en, step_dn, byte_op, mod_en, mod_start, mod_end,
                 brev_en, brev_mod, input next);
   modport agu  (input ptr, step_en, step_dn, byte_op, mod_en, mod_start, mod_end,
                 brev_en, brev_mod, output next);
endinterface

/* File: logic/dsau_agu.sv */
// post-modify address generator with modulo wrap and bit-reversed carry
`timescale 1ns/1ps
module dsau_agu import dsau_pkg::*; (
   dsau_agu_if.agu a
);
   logic [15:0] step;
   logic [15:0] sum;
   logic [16:0] len;
   logic [16:0] up_sum;
   logic        wrap_up;
   logic        wrap_dn;
   logic [15:0] ptr_rev;
   logic [15:0] mod_rev;
   logic [15:0] rev_sum;
   logic [15:0] brev_next;

   // ==========================================================
   // scaled step
   assign step   = a.byte_op ? STEP_BYTE : STEP_WORD;
   assign sum    = a.step_dn ? (a.ptr - step) : (a.ptr + step);
   assign up_sum = {1'b0, a.ptr} + {1'b0, step};

   // length from the end and start pair, up to 64 kbytes
   assign len = {1'b0, a.mod_end} - {1'b0, a.mod_start} + 17'h00001;

   // wrap only a pointer that sat on the inner side of the crossed bound (end going up, start going down) before the step
   assign wrap_up = !a.step_dn && (a.ptr <= a.mod_end) && (up_sum > {1'b0, a.mod_end});
   assign wrap_dn = a.step_dn && (a.ptr >= a.mod_start)
                    && ({1'b0, a.ptr} < ({1'b0, a.mod_start} + {1'b0, step}));

   // ==========================================================
   // reversed carry: reverse, add, reverse back
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_rev
         assign ptr_rev[i]   = a.ptr[15 - i];
         // only the low modifier byte exists; a ternary would index past it
         if (i < 8) begin : g_lo
            assign mod_rev[i] = 1'b0;
         end else begin : g_hi
            assign mod_rev[i] = a.brev_mod[15 - i];
         end
         assign brev_next[i] = rev_sum[15 - i];
      end
   endgenerate
   assign rev_sum = ptr_rev + mod_rev;

   // ==========================================================
   // result select, bit reversal wins over modulo
   always_comb begin
      if (a.brev_en) begin
         a.next = brev_next;
      end else if (!a.step_en) begin
         a.next = a.ptr;
      end else if (a.mod_en && wrap_up) begin
         a.next = sum - len[15:0];
      end else if (a.mod_en && wrap_dn) begin
         a.next = sum + len[15:0];
      end else begin
         a.next = sum;
      end
   end
endmodule

/* File: logic/dsau_ram.sv */
// data ram of two byte lanes with shared word decode
`timescale 1ns/1ps
module dsau_ram import dsau_pkg::*; (
   input  wire logic              clk,
   input  wire logic [1:0]        we_lane,
   input  wire logic [RAM_AW-1:0] waddr,
   input  wire logic [15:0]       wdata,
   input  wire logic [RAM_AW-1:0] xaddr,
   output      logic [15:0]       xq,
   input  wire logic [RAM_AW-1:0] yaddr,
   output      logic [15:0]       yq
);
   // ==========================================================
   // one array per lane, separate write lines
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lane
         logic [7:0] mem [RAM_WORDS];
         always_ff @(posedge clk) begin
            if (we_lane[g]) begin
               mem[waddr] <= wdata[8*g +: 8];
            end
         end
         assign xq[8*g +: 8] = mem[xaddr];
         assign yq[8*g +: 8] = mem[yaddr];
      end
   endgenerate
endmodule

/* File: logic/dsau_top.sv */
// data space address unit: x/y data paths, alignment, modulo regs over apb
`timescale 1ns/1ps
module dsau_top import dsau_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        x_valid,
   input  wire logic        x_write,
   input  wire logic        x_byte,
   input  wire logic        x_mac,
   input  wire logic        x_writeback,
   input  wire logic [3:0]  x_ptr_sel,
   input  wire logic [15:0] x_ea,
   input  wire logic        x_step_en,
   input  wire logic        x_step_dn,
   input  wire logic [15:0] x_wdata,
   input  wire logic        y_valid,
   input  wire logic [3:0]  y_ptr_sel,
   input  wire logic [15:0] y_ea,
   input  wire logic        y_step_en,
   input  wire logic        y_step_dn,
   output      logic [15:0] x_rdata,
   output      logic        x_rvalid,
   output      logic [15:0] x_ptr_next,
   output      logic [15:0] y_rdata,
   output      logic        y_rvalid,
   output      logic [15:0] y_ptr_next,
   output      logic        addr_error_trap
);
   // ==========================================================
   // declarations
   logic [15:0]       modulo_control_reg;
   logic [15:0]       x_buffer_start_reg;
   logic [15:0]       x_buffer_end_reg;
   logic [15:0]       y_buffer_start_reg;
   logic [15:0]       y_buffer_end_reg;
   logic [15:0]       bitrev_control_reg;
   logic [15:0]       error_address_reg;
   logic              error_seen_reg;
   logic [31:0]       prdata_reg;
   logic              pslverr_reg;
   logic [15:0]       x_rdata_reg;
   logic              x_rvalid_reg;
   logic [15:0]       x_ptr_next_reg;
   logic [15:0]       y_rdata_reg;
   logic              y_rvalid_reg;
   logic [15:0]       y_ptr_next_reg;
   logic              addr_error_trap_reg;
   logic              apb_wr;
   logic              apb_setup;
   logic [15:0]       wr_val;
   logic [15:0]       rd_val;
   logic              rd_hit;
   logic [3:0]        x_modulo_pointer_select;
   logic [3:0]        y_modulo_pointer_select;
   logic              x_modulo_enable;
   logic              y_modulo_enable;
   logic              x_in_ram;
   logic              x_in_y;
   logic              x_misalign;
   logic              x_mac_ptr_ok;
   logic              x_restrict;
   logic              x_read_ok;
   logic              x_wr_ok;
   logic              y_in_y;
   logic              y_misalign;
   logic              y_ptr_ok;
   logic              y_read_ok;
   logic [15:0]       x_off;
   logic [15:0]       y_off;
   logic [1:0]        we_lane;
   logic [15:0]       ram_wdata;
   logic [15:0]       ram_xq;
   logic [15:0]       ram_yq;
   logic [15:0]       x_rd_val;
   logic              err_set;

   dsau_agu_if x_agu ();
   dsau_agu_if y_agu ();

   // ==========================================================
   // apb slave, zero wait states
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite;
   assign wr_val    = pwdata[15:0]; // upper half ignored, reads zero
   assign pready    = 1'b1;
   assign prdata    = prdata_reg;
   assign pslverr   = pslverr_reg;

   // buffer address and control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modulo_control_reg <= MODULO_CONTROL_RST;
         x_buffer_start_reg <= BUFFER_ADDR_RST;
         x_buffer_end_reg   <= BUFFER_ADDR_RST;
         y_buffer_start_reg <= BUFFER_ADDR_RST;
         y_buffer_end_reg   <= BUFFER_ADDR_RST;
         bitrev_control_reg <= BITREV_CONTROL_RST;
      end else if (apb_wr) begin
         if (paddr == OFF_MODULO_CONTROL) begin
            modulo_control_reg <= wr_val;
         end else if (paddr == OFF_X_BUFFER_START) begin
            x_buffer_start_reg <= wr_val;
         end else if (paddr == OFF_X_BUFFER_END) begin
            x_buffer_end_reg <= wr_val;
         end else if (paddr == OFF_Y_BUFFER_START) begin
            y_buffer_start_reg <= wr_val;
         end else if (paddr == OFF_Y_BUFFER_END) begin
            y_buffer_end_reg <= wr_val;
         end else if (paddr == OFF_BITREV_CONTROL) begin
            bitrev_control_reg <= wr_val;
         end
      end
   end

   // read decode; the x/y boundary has no register at all
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      if (paddr == OFF_MODULO_CONTROL) begin
         rd_val = modulo_control_reg;
      end else if (paddr == OFF_X_BUFFER_START) begin
         rd_val = x_buffer_start_reg;
      end else if (paddr == OFF_X_BUFFER_END) begin
         rd_val = x_buffer_end_reg;
      end else if (paddr == OFF_Y_BUFFER_START) begin
         rd_val = y_buffer_start_reg;
      end else if (paddr == OFF_Y_BUFFER_END) begin
         rd_val = y_buffer_end_reg;
      end else if (paddr == OFF_BITREV_CONTROL) begin
         rd_val = bitrev_control_reg;
      end else if (paddr == OFF_ERROR_ADDRESS) begin
         rd_val = error_address_reg;
      end else if (paddr == OFF_ERROR_FLAGS) begin
         rd_val = {15'h0000, error_seen_reg};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // read data and error caught in the setup cycle, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (apb_setup) begin
         prdata_reg  <= pwrite ? 32'h00000000 : {16'h0000, rd_val};
         pslverr_reg <= !rd_hit;
      end
   end

   // ==========================================================
   // control fields
   assign x_modulo_pointer_select = modulo_control_reg[X_SEL_LSB +: 4];
   assign y_modulo_pointer_select = modulo_control_reg[Y_SEL_LSB +: 4];
   assign x_modulo_enable         = modulo_control_reg[X_ENABLE_BIT];
   assign y_modulo_enable         = modulo_control_reg[Y_ENABLE_BIT];

   // ==========================================================
   // x path decode, 16-bit byte effective address
   assign x_in_ram     = (x_ea >= RAM_FIRST) && (x_ea <= RAM_LAST);
   assign x_in_y       = (x_ea >= Y_SPACE_FIRST) && (x_ea <= Y_SPACE_LAST);
   assign x_misalign   = !x_byte && x_ea[0];
   assign x_mac_ptr_ok = (x_ptr_sel == X_PREFETCH_POINTER_A)
                         || (x_ptr_sel == X_PREFETCH_POINTER_B);
   // write-back and plain instructions see the combined linear space
   assign x_restrict   = x_mac && !x_writeback && !x_write;
   assign x_read_ok    = x_in_ram && (!x_restrict || (x_mac_ptr_ok && !x_in_y));
   // a misaligned write runs but never reaches memory
   assign x_wr_ok      = x_valid && x_write && x_in_ram && !x_misalign;
   assign x_off        = x_ea - RAM_FIRST;

   // ==========================================================
   // y path decode: word prefetch only, no write port exists
   assign y_in_y       = (y_ea >= Y_SPACE_FIRST) && (y_ea <= Y_SPACE_LAST);
   assign y_misalign   = y_ea[0];
   assign y_ptr_ok     = (y_ptr_sel == Y_PREFETCH_POINTER_A)
                         || (y_ptr_sel == Y_PREFETCH_POINTER_B);
   assign y_read_ok    = y_in_y && y_ptr_ok;
   assign y_off        = y_ea - RAM_FIRST;

   // ==========================================================
   // write lanes; a byte is copied to both lanes, only one strobes
   always_comb begin
      we_lane   = 2'b00;
      ram_wdata = x_wdata; // only write path into data space
      if (x_wr_ok && x_byte) begin
         we_lane   = x_ea[0] ? 2'b10 : 2'b01;
         ram_wdata = {x_wdata[7:0], x_wdata[7:0]};
      end else if (x_wr_ok) begin
         we_lane = 2'b11;
      end
   end

   dsau_ram u_ram (
      .clk     (pclk),
      .we_lane (we_lane),
      .waddr   (x_off[RAM_AW:1]),
      .wdata   (ram_wdata),
      .xaddr   (x_off[RAM_AW:1]),
      .xq      (ram_xq),
      .yaddr   (y_off[RAM_AW:1]),
      .yq      (ram_yq)
   );

   // byte select onto the low byte, zero outside space or memory
   always_comb begin
      x_rd_val = 16'h0000;
      if (x_read_ok && x_byte) begin
         x_rd_val = {8'h00, x_ea[0] ? ram_xq[15:8] : ram_xq[7:0]};
      end else if (x_read_ok) begin
         x_rd_val = ram_xq; // odd word read still completes on the even word
      end
   end

   // ==========================================================
   // registered read buses, separate from the write bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_rdata_reg  <= 16'h0000;
         x_rvalid_reg <= 1'b0;
         y_rdata_reg  <= 16'h0000;
         y_rvalid_reg <= 1'b0;
      end else begin
         x_rvalid_reg <= x_valid && !x_write;
         y_rvalid_reg <= y_valid;
         if (x_valid && !x_write) begin
            x_rdata_reg <= x_rd_val;
         end
         if (y_valid) begin
            y_rdata_reg <= y_read_ok ? ram_yq : 16'h0000;
         end
      end
   end

   // ==========================================================
   // pointer post-modify requests
   assign x_agu.ptr       = x_ea;
   assign x_agu.step_en   = x_step_en;
   assign x_agu.step_dn   = x_step_dn;
   assign x_agu.byte_op   = x_byte;
   assign x_agu.mod_en    = x_modulo_enable && (x_modulo_pointer_select != SEL_DISABLED)
                            && (x_ptr_sel == x_modulo_pointer_select);
   assign x_agu.mod_start = x_buffer_start_reg;
   assign x_agu.mod_end   = x_buffer_end_reg;
   assign x_agu.brev_en   = bitrev_control_reg[BREV_ENABLE_BIT] && x_write
                            && (x_ptr_sel == bitrev_control_reg[BREV_SEL_LSB +: 4]);
   assign x_agu.brev_mod  = bitrev_control_reg[BREV_MOD_LSB +: 8];

   // y pointers always step by words and never bit-reverse
   assign y_agu.ptr       = y_ea;
   assign y_agu.step_en   = y_step_en;
   assign y_agu.step_dn   = y_step_dn;
   assign y_agu.byte_op   = 1'b0;
   assign y_agu.mod_en    = y_modulo_enable && (y_modulo_pointer_select != SEL_DISABLED)
                            && (y_ptr_sel == y_modulo_pointer_select);
   assign y_agu.mod_start = y_buffer_start_reg;
   assign y_agu.mod_end   = y_buffer_end_reg;
   assign y_agu.brev_en   = 1'b0;
   assign y_agu.brev_mod  = 8'h00;

   dsau_agu u_x_agu (
      .a (x_agu)
   );

   dsau_agu u_y_agu (
      .a (y_agu)
   );

   // updated pointers for the core to write back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_ptr_next_reg <= 16'h0000;
         y_ptr_next_reg <= 16'h0000;
      end else begin
         if (x_valid) begin
            x_ptr_next_reg <= x_agu.next;
         end
         if (y_valid) begin
            y_ptr_next_reg <= y_agu.next;
         end
      end
   end

   // ==========================================================
   // address error trap, one cycle after the faulting access
   assign err_set = (x_valid && x_misalign) || (y_valid && y_misalign);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_error_trap_reg <= 1'b0;
         error_address_reg   <= 16'h0000;
      end else begin
         addr_error_trap_reg <= err_set;
         if (x_valid && x_misalign) begin
            error_address_reg <= x_ea;
         end else if (y_valid && y_misalign) begin
            error_address_reg <= y_ea;
         end
      end
   end

   // sticky flag; a new fault in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_seen_reg <= 1'b0;
      end else if (err_set) begin
         error_seen_reg <= 1'b1;
      end else if (apb_wr && (paddr == OFF_ERROR_FLAGS) && pwdata[ERR_SEEN_BIT]) begin
         error_seen_reg <= 1'b0;
      end
   end

   // ==========================================================
   // outputs
   assign x_rdata         = x_rdata_reg;
   assign x_rvalid        = x_rvalid_reg;
   assign x_ptr_next      = x_ptr_next_reg;
   assign y_rdata         = y_rdata_reg;
   assign y_rvalid        = y_rvalid_reg;
   assign y_ptr_next      = y_ptr_next_reg;
   assign addr_error_trap = addr_error_trap_reg;
endmodule

/* File: tb/dsau_props.sv */
// port assertions of the data space address unit
`timescale 1ns/1ps
module dsau_props import dsau_pkg::*; (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        x_valid,
   input wire logic        x_write,
   input wire logic        x_byte,
   input wire logic [15:0] x_ea,
   input wire logic        y_valid,
   input wire logic [15:0] y_ea,
   input wire logic [15:0] x_rdata,
   input wire logic        x_rvalid,
   input wire logic [15:0] y_rdata,
   input wire logic        y_rvalid,
   input wire logic        addr_error_trap
);
   // ==========
   // one clock, one reset for every property
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_read_answer: assert property (x_valid && !x_write |=> x_rvalid)
      else $error("x read gave no answer");
   a_write_silent: assert property (x_valid && x_write |=> !x_rvalid)
      else $error("x write produced read data");
   a_y_answer: assert property (y_valid |=> y_rvalid)
      else $error("y prefetch gave no answer");
   a_byte_lane: assert property (
      x_valid && !x_write && x_byte |=> x_rdata[15:8] == 8'h00)
      else $error("byte read high lane not zero");
   a_outside_zero: assert property (
      x_valid && !x_write && (x_ea < RAM_FIRST || x_ea > RAM_LAST) |=> x_rdata == 16'h0000)
      else $error("read outside memory not zero");
   a_y_space_zero: assert property (
      y_valid && (y_ea < Y_SPACE_FIRST || y_ea > Y_SPACE_LAST) |=> y_rdata == 16'h0000)
      else $error("y read outside y space not zero");
   a_odd_trap: assert property (
      (x_valid && !x_byte && x_ea[0]) || (y_valid && y_ea[0]) |=> addr_error_trap)
      else $error("odd word access did not trap");
   a_trap_cause: assert property (
      !((x_valid && !x_byte && x_ea[0]) || (y_valid && y_ea[0])) |=> !addr_error_trap)
      else $error("trap without a misaligned access");
endmodule

bind dsau_top dsau_props dsau_props_i (.pclk, .presetn, .x_valid, .x_write, .x_byte, .x_ea,
   .y_valid, .y_ea, .x_rdata, .x_rvalid, .y_rdata, .y_rvalid, .addr_error_trap);

/* File: tb/dsau_core_model.sv */
// core-side model issuing x and y data space requests
`timescale 1ns/1ps
module dsau_core_model (
   input  wire logic        pclk,
   output      logic        x_valid,
   output      logic        x_write,
   output      logic        x_byte,
   output      logic        x_mac,
   output      logic        x_writeback,
   output      logic [3:0]  x_ptr_sel,
   output      logic [15:0] x_ea,
   output      logic        x_step_en,
   output      logic        x_step_dn,
   output      logic [15:0] x_wdata,
   output      logic        y_valid,
   output      logic [3:0]  y_ptr_sel,
   output      logic [15:0] y_ea,
   output      logic        y_step_en,
   output      logic        y_step_dn
);
   // ==========
   // idle at time zero; post-modify always on, y only counts up
   initial begin
      {x_valid, x_write, x_byte, x_mac, x_writeback, x_step_dn, y_valid, y_step_dn} = '0;
      {x_ptr_sel, y_ptr_sel, x_ea, y_ea, x_wdata} = '0;
      x_step_en = 1'b1;
      y_step_en = 1'b1;
   end
   // one x request for one taking edge; address and write data go stale-inverted after it
   task automatic xreq(input logic [4:0] f, input logic [3:0] s, input logic [15:0] e, d);
      @(posedge pclk);
      {x_write, x_byte, x_mac, x_writeback, x_step_dn} <= f;
      x_valid <= 1'b1;
      x_ptr_sel <= s;
      x_ea <= e;
      x_wdata <= d;
      @(posedge pclk);
      x_valid <= 1'b0;
      x_ea <= ~e;
      x_wdata <= ~d;
      #1;
   endtask
   // y side only prefetches words, it never writes
   task automatic yreq(input logic [3:0] s, input logic [15:0] e);
      @(posedge pclk);
      y_valid <= 1'b1;
      y_ptr_sel <= s;
      y_ea <= e;
      @(posedge pclk);
      y_valid <= 1'b0;
      y_ea <= ~e;
      #1;
   endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench of the data space address unit
`timescale 1ns/1ps
module tb import dsau_pkg::*;;
   typedef struct {logic [4:0] f; logic [3:0] s; logic [15:0] e, d, x; logic t;} dsau_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        x_valid, x_write, x_byte, x_mac, x_writeback, x_step_en, x_step_dn;
   logic        y_valid, y_step_en, y_step_dn, x_rvalid, y_rvalid, addr_error_trap;
   logic [3:0]  x_ptr_sel, y_ptr_sel;
   logic [15:0] x_ea, x_wdata, y_ea, x_rdata, x_ptr_next, y_rdata, y_ptr_next, stp;
   int          checks = 0;
   int          bad_count = 0;
   // f holds write, byte, mac, write-back, step down
   dsau_row_t rows [13] = '{'{5'h10, 4'h1, 16'h0800, 16'h1234, 16'h0000, 1'b0},
      '{5'h18, 4'h1, 16'h0801, 16'h00AB, 16'h0000, 1'b0},
      '{5'h00, 4'h1, 16'h0800, 16'h0000, 16'hAB34, 1'b0},
      '{5'h08, 4'h1, 16'h0801, 16'h0000, 16'h00AB, 1'b0},
      '{5'h09, 4'h1, 16'h0800, 16'h0000, 16'h0034, 1'b0},
      '{5'h00, 4'h1, 16'h0100, 16'h0000, 16'h0000, 1'b0},
      '{5'h12, 4'h1, 16'h0A00, 16'h5678, 16'h0000, 1'b0},
      '{5'h04, 4'h8, 16'h0A00, 16'h0000, 16'h0000, 1'b0},
      '{5'h04, 4'h9, 16'h0800, 16'h0000, 16'hAB34, 1'b0},
      '{5'h00, 4'h1, 16'h0A00, 16'h0000, 16'h5678, 1'b0},
      '{5'h10, 4'h1, 16'h0801, 16'hFFFF, 16'h0000, 1'b1},
      '{5'h01, 4'h1, 16'h0800, 16'h0000, 16'hAB34, 1'b0},
      '{5'h00, 4'h1, 16'h0801, 16'h0000, 16'hAB34, 1'b1}};
   logic [31:0] cv [5] = '{32'h0000C0A2, 32'h00000800, 32'hFFFF0807, 32'h00000A00, 32'h00000A03};

   dsau_top dsau_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .x_valid, .x_write, .x_byte, .x_mac, .x_writeback, .x_ptr_sel, .x_ea,
      .x_step_en, .x_step_dn, .x_wdata, .y_valid, .y_ptr_sel, .y_ea, .y_step_en, .y_step_dn,
      .x_rdata, .x_rvalid, .x_ptr_next, .y_rdata, .y_rvalid, .y_ptr_next, .addr_error_trap);
   dsau_core_model dsau_core_model_i (.pclk, .x_valid, .x_write, .x_byte, .x_mac, .x_writeback,
      .x_ptr_sel, .x_ea, .x_step_en, .x_step_dn, .x_wdata, .y_valid, .y_ptr_sel, .y_ea,
      .y_step_en, .y_step_dn);

   // ==========
   // clock and hang guard, about thirty times the expected run
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      #(25 * 3000);
      bad_count++;
      complete_run();
   end
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // apb transfer; holds the request until pready is seen at an edge
   // only the watchdog ends a wait for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic complete_run;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========
   // main sequence: table of x accesses, then registers and modulo cases
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         dsau_core_model_i.xreq(rows[i].f, rows[i].s, rows[i].e, rows[i].d);
         stp = rows[i].f[3] ? STEP_BYTE : STEP_WORD;
         if (!rows[i].f[4]) chk(x_rdata, rows[i].x);
         chk(addr_error_trap, rows[i].t);
         chk(x_ptr_next, rows[i].f[0] ? rows[i].e - stp : rows[i].e + stp);
      end
      $display("x access table done");
      apb(1'b0, OFF_MODULO_CONTROL, 32'h0);
      chk(rd, 32'h000000FF);
      apb(1'b1, 8'h20, 32'h1);
      chk(er, 1'b1);
      for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), cv[i]);
      apb(1'b0, OFF_X_BUFFER_END, 32'h0);
      chk(rd, 32'h00000807);
      $display("register test done");
      dsau_core_model_i.xreq(5'h00, 4'h2, 16'h0806, 16'h0);
      chk(x_ptr_next, 16'h0800);
      dsau_core_model_i.xreq(5'h01, 4'h2, 16'h0800, 16'h0);
      chk(x_ptr_next, 16'h0806);
      dsau_core_model_i.xreq(5'h00, 4'h3, 16'h0806, 16'h0);
      chk(x_ptr_next, 16'h0808);
      dsau_core_model_i.yreq(4'hA, 16'h0A00);
      chk({y_rdata, y_ptr_next}, 32'h56780A02);
      dsau_core_model_i.yreq(4'hA, 16'h0A02);
      chk(y_ptr_next, 16'h0A00);
      dsau_core_model_i.yreq(4'hB, 16'h0800);
      chk(y_rdata, 16'h0000);
      dsau_core_model_i.yreq(4'hA, 16'h0A01);
      chk(addr_error_trap, 1'b1);
      apb(1'b1, OFF_MODULO_CONTROL, 32'h000080FF);
      dsau_core_model_i.xreq(5'h00, 4'hF, 16'h0806, 16'h0);
      chk(x_ptr_next, 16'h0808);
      $display("modulo test done");
      // bit reversal steps x writes only; the read with the same pointer steps plainly
      apb(1'b1, OFF_BITREV_CONTROL, 32'h00008408);
      dsau_core_model_i.xreq(5'h10, 4'h4, 16'h0808, 16'hC3C3);
      chk(x_ptr_next, 16'h0804);
      dsau_core_model_i.xreq(5'h00, 4'h4, 16'h0808, 16'h0000);
      chk({x_rdata, x_ptr_next}, 32'hC3C3080A);
      apb(1'b0, OFF_ERROR_ADDRESS, 32'h0);
      chk(rd, 32'h00000A01);
      apb(1'b0, OFF_ERROR_FLAGS, 32'h0);
      chk(rd, 32'h00000001);
      apb(1'b1, OFF_ERROR_FLAGS, 32'h1);
      apb(1'b0, OFF_ERROR_FLAGS, 32'h0);
      chk(rd, 32'h00000000);
      $display("bitrev and error test done");
      // reset in mid-run: outputs clear, control back to its disabled default
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({x_rdata, x_ptr_next}, 32'h0);
      chk(y_ptr_next, 16'h0000);
      chk(addr_error_trap, 1'b0);
      presetn <= 1'b1;
      apb(1'b0, OFF_MODULO_CONTROL, 32'h0);
      chk(rd, 32'h000000FF);
      $display("mid-run reset test done");
      complete_run();
   end
endmodule
